//--- bench/bfm_breaker_model.sv
// breaker model: position contact and line current of the monitored breaker
`timescale 1ns/100ps
module bfm_breaker_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        open_cmd_i, // own trip of the breaker
    input  wire logic        close_i,    // closing attempt
    input  wire logic        lockout_i,  // latched failure, blocks closing
    input  wire logic [15:0] load_i,     // current while closed
    output logic             pos_open_o,
    output logic      [15:0] cur_o
);
    int cnt; // opening delay, well inside the supervision time
    // contact mechanism
    always @(posedge clk_i) begin
        if (rst_i) begin
            pos_open_o <= 1'b0;
            cnt        <= 0;
        end else if (open_cmd_i && !pos_open_o) begin
            cnt <= cnt + 1;
            if (cnt == 4) pos_open_o <= 1'b1;
        end else if (close_i && !lockout_i) begin
            pos_open_o <= 1'b0;
            cnt        <= 0;
        end
    end
    // current dies with the contacts; small load covers the standby case
    assign cur_o = pos_open_o ? 16'h0000 : load_i;
endmodule // bfm_breaker_model

//--- bench/bfm_monitor_bench.sv
// self-checking bench for the breaker failure monitor
`timescale 1ns/100ps
module bfm_monitor_bench;
    import bfm_pkg::*;
    localparam int T = 20; // shortened supervision time of set 1
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [7:0]  trip_all_i = 8'h00;
    logic [7:0]  trip_ext_i = 8'h00;
    logic [2:0]  extra_trig_i = 3'h0;
    logic [15:0] cur_neutral_i = 16'h0000;
    logic [15:0] cur_terminal;
    logic [15:0] freq_meas_i = 16'h03e8;
    logic        pos_open;
    logic        open_cmd = 1'b0;
    logic        close_cmd = 1'b0;
    logic        backup_trip_o;
    logic        lockout_o;
    int          n_fail = 0;
    int          checked = 0;
    // case codes: [1:0] scheme [2] terminal [3] opens [4] neutral high
    // [5] off frequency [7:6] trigger mode [8] external [9] assigned trip
    int cases[$] = '{132, 140, 133, 141, 134, 142, 128, 154, 162, 130,
                     1, 257, 65, 321, 641, 164};
    always #20 clk_i = ~clk_i;
    bfm_monitor i_bfm_monitor (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .trip_all_i(trip_all_i), .trip_ext_i(trip_ext_i), .extra_trig_i(extra_trig_i),
        .cur_neutral_i(cur_neutral_i), .cur_terminal_i(cur_terminal),
        .pos_open_i(pos_open), .freq_meas_i(freq_meas_i), .freq_nom_i(16'h03e8),
        .backup_trip_o(backup_trip_o), .lockout_o(lockout_o));
    bfm_breaker_model i_bfm_breaker_model (
        .clk_i(clk_i), .rst_i(rst_i), .open_cmd_i(open_cmd), .close_i(close_cmd),
        .lockout_i(lockout_o), .load_i(16'h0200), .pos_open_o(pos_open),
        .cur_o(cur_terminal));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle; entered just after a rising edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        for (k = 0; k < 8 && wb_ack_o !== 1'b1; k++) begin
            @(posedge clk_i);
        end
        if (k == 8) begin
            n_fail++;
            report_and_stop();
        end else begin
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), q, e);
    endtask
    // reference: does this case end in a breaker failure
    function automatic int fails(int c);
        int  m;
        bit  start;
        bit  cur_hi;
        m = (c >> 6) & 3;
        start = (m == 2 && !c[9]) || m == 0 || (m == 1 && c[8]);
        cur_hi = c[2] ? !c[3] : c[4];
        if (!start) return 0;
        // off frequency blocks the current criterion, so no opening is seen
        if ((c & 3) == 0) return int'(cur_hi || c[5]);
        if ((c & 3) == 1 || c[5]) return int'(!c[3]);
        return int'(cur_hi && !c[3]);
    endfunction
    // watch the trip for a fixed window; trigger dropped early unless held
    task automatic watch(input int ef, input bit hold);
        int hit;
        hit = 0;
        for (int n = 1; n <= 2 * T; n++) begin
            @(posedge clk_i);
            if (n == 2 && !hold) begin
                trip_all_i   <= 8'h00;
                extra_trig_i <= 3'h0;
            end
            if (hit != 0 && n == hit + 1) chk("trip pulse", backup_trip_o, 32'h0);
            if (hit == 0 && backup_trip_o === 1'b1) hit = n;
        end
        // one edge takes the trigger, then T cycles of running
        chk("trip time", hit, ef ? T + 2 : 0);
        chk("lockout", lockout_o, 32'(ef));
    endtask
    task automatic run(input int c);
        logic [31:0] q;
        int          ef;
        ef = fails(c);
        wr(REG_CTRL, 32'h20 | 32'((c >> 6) & 3) << CTRL_TRIG_LSB
                     | 32'(c[2]) << CTRL_XSEL_BIT | 32'(c & 3));
        cur_neutral_i <= c[4] ? 16'h00c0 : 16'($urandom_range(127));
        freq_meas_i   <= c[5] ? 16'h044c : 16'h03e8;
        repeat (2) @(posedge clk_i);
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk("status idle", q & 32'h3f, 32'(c[5]) << 5);
        if (((c >> 6) & 3) == 2 && !c[9]) extra_trig_i <= 3'h1 << $urandom_range(2);
        else trip_all_i <= 8'h01 << $urandom_range(7);
        trip_ext_i <= c[8] ? 8'hff : 8'h00;
        open_cmd   <= c[3];
        watch(ef, c[3]);
        if (c[3] && ef == 0) begin
            rchk(REG_STATUS, 32'h12);
            trip_all_i   <= 8'h00;
            extra_trig_i <= 3'h0;
            repeat (2) @(posedge clk_i);
            rchk(REG_STATUS, 32'h0);
        end
        if (ef != 0) begin
            wr(REG_ACK, 32'h1);
            chk("lockout clear", lockout_o, 32'h0);
        end
        open_cmd  <= 1'b0;
        close_cmd <= 1'b1;
        @(posedge clk_i);
        close_cmd <= 1'b0;
        @(posedge clk_i);
        $display("test case %0d done", c);
    endtask
    initial begin
        void'($urandom(41373));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rchk(REG_CTRL, CTRL_RST);
        rchk(REG_THR0, 32'(THR_RST));
        rchk(REG_THR0 + 8'h0c, 32'(THR_RST));
        rchk(REG_TIME0, 32'(TIME_RST));
        rchk(REG_STATUS, 32'h0);
        rchk(8'h3c, 32'h0);
        $display("test reset values done");
        wr(REG_TIME0 + REG_STRIDE, 32'(T));
        wr(REG_THR0 + REG_STRIDE, 32'h80);
        rchk(REG_TIME0 + REG_STRIDE, 32'(T));
        $display("test set config done");
        foreach (cases[i]) run(cases[i]);
        report_and_stop();
    end
endmodule // bfm_monitor_bench

//--- rtl/bfm_freq_check.sv
// frequency deviation detector that blocks the current criterion
`timescale 1ns/100ps
module bfm_freq_check #(
    parameter int FW = 16
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [FW-1:0] freq_meas_i,   // measured frequency, any unit
    input  wire logic [FW-1:0] freq_nom_i,    // nominal frequency, same unit
    output logic               off_nominal_o  // deviation beyond margin
);
    import bfm_pkg::*;

    typedef struct packed {
        logic off;
    } bfm_fc_state_t;

    bfm_fc_state_t s_q;
    bfm_fc_state_t s_d;

    // ------------------------------------------------------------
    // deviation compare: |f - fn| * 100 > fn * 5
    // ------------------------------------------------------------
    always_comb begin
        logic [FW-1:0] diff;
        logic [FW+7:0] lhs;
        logic [FW+7:0] rhs;
        diff = (freq_meas_i > freq_nom_i) ? freq_meas_i - freq_nom_i
                                          : freq_nom_i - freq_meas_i;
        lhs  = FW'(0) + ({8'h00, diff} * (FW+8)'(100));
        rhs  = {8'h00, freq_nom_i} * (FW+8)'(FREQ_PCT);
        s_d.off = (lhs > rhs);
    end

    // registered so the decision is glitch free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign off_nominal_o = s_q.off;
endmodule // bfm_freq_check

//--- rtl/bfm_monitor.sv
// breaker failure monitor top with wishbone register slave
// Notes on behaviour
// RULE_01 - setting picks neutral or terminal transformer current
// RULE_02 - current scheme fails if current stays high
// RULE_03 - position scheme fails if breaker not open
// RULE_04 - combined fails only if both show closed
// RULE_05 - position scheme suits low load cases
// RULE_06 - off frequency blocks current criterion
// RULE_07 - timer keeps running after trigger drops
// RULE_08 - expiry asserts backup trip for upstream breaker
// RULE_09 - supervision time exceeds sum of delays
// RULE_10 - detected opening stops the timer
// RULE_11 - opening with trigger active enters rejected
// RULE_12 - rejected returns to standby when triggers drop
// RULE_13 - lockout with trip, held until acknowledge
// RULE_14 - lockout may inhibit breaker closing
// RULE_15 - all-trips mode uses every assigned trip
// RULE_16 - external mode uses external trips only
// RULE_17 - three extra inputs always may trigger
// RULE_18 - no-assignment mode leaves extra inputs only
// RULE_19 - threshold and time from active set
// RULE_20 - effective trigger is OR, rising edge starts
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module bfm_monitor #(
    parameter int NT = 8,   // number of assigned trip sources
    parameter int FW = 16   // frequency word width
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // wishbone classic slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // trip sources
    input  wire logic [NT-1:0]             trip_all_i,
    input  wire logic [NT-1:0]             trip_ext_i,
    input  wire logic [2:0]                extra_trig_i,
    // breaker measurements
    input  wire logic [bfm_pkg::CUR_W-1:0] cur_neutral_i,
    input  wire logic [bfm_pkg::CUR_W-1:0] cur_terminal_i,
    input  wire logic                      pos_open_i,
    input  wire logic [FW-1:0]             freq_meas_i,
    input  wire logic [FW-1:0]             freq_nom_i,
    // outputs
    output logic                           backup_trip_o,
    output logic                           lockout_o
);
    import bfm_pkg::*;

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]              ctrl;
        logic [NUM_SETS-1:0][15:0] thr;
        logic [NUM_SETS-1:0][23:0] tim;
        bfm_state_t               st;
        logic [TIME_W-1:0]        cnt;
        logic                     trip;
        logic                     lock;
        logic                     ack;
        logic [31:0]              rdat;
    } bfm_state_rec_t;

    bfm_state_rec_t s_q;        // registered state
    bfm_state_rec_t s_d;        // next state
    logic           trig;       // effective trigger level
    logic           trig_rise;  // trigger start edge
    logic           off_nom;    // frequency out of band

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // merge a write word through the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    bfm_trigger #(.NT(NT)) u_trig (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .mode_i       (s_q.ctrl[CTRL_TRIG_LSB +: 2]),
        .trip_all_i   (trip_all_i),
        .trip_ext_i   (trip_ext_i),
        .extra_trig_i (extra_trig_i),
        .trig_o       (trig),
        .trig_rise_o  (trig_rise)
    );

    bfm_freq_check #(.FW(FW)) u_freq (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .freq_meas_i   (freq_meas_i),
        .freq_nom_i    (freq_nom_i),
        .off_nominal_o (off_nom)
    );

    // ------------------------------------------------------------
    // criterion decode
    // ------------------------------------------------------------
    logic [1:0]        set_sel;   // active parameter set
    logic [CUR_W-1:0]  cur_sel;   // monitored current
    logic [CUR_W-1:0]  thr_act;   // active threshold
    logic [TIME_W-1:0] tim_act;   // active supervision time
    logic              cur_open;  // current shows breaker open
    logic              opened;    // scheme sees breaker open

    always_comb begin
        set_sel = s_q.ctrl[CTRL_SET_LSB +: 2];
        thr_act = s_q.thr[set_sel];                               // RULE_19
        tim_act = s_q.tim[set_sel];                               // RULE_19
        // terminal side is the safe pick; neutral keeps feeding faults
        cur_sel = s_q.ctrl[CTRL_XSEL_BIT] ? cur_terminal_i
                                          : cur_neutral_i;        // RULE_01
        cur_open = (cur_sel < thr_act);                           // RULE_02
        case (bfm_scheme_t'(s_q.ctrl[CTRL_SCHEME_LSB +: 2]))
            // blocked scheme never sees an opening, so it cannot stop
            SCH_CURRENT:  opened = cur_open & ~off_nom;           // RULE_02 RULE_06
            SCH_POSITION: opened = pos_open_i;                    // RULE_03
            SCH_COMBINED: opened = off_nom ? pos_open_i
                                   : (cur_open | pos_open_i);     // RULE_04 RULE_06
            default:      opened = pos_open_i;
        endcase
    end

    // ------------------------------------------------------------
    // next state: monitor and bus
    // ------------------------------------------------------------
    always_comb begin
        logic acc;
        logic wr;
        s_d  = s_q;
        acc  = wb_cyc_i & wb_stb_i & ~s_q.ack;
        wr   = acc & wb_we_i;
        s_d.ack  = acc;
        s_d.trip = 1'b0;
        // monitor sequence
        case (s_q.st)
            ST_STANDBY: begin
                if (trig_rise) begin                              // RULE_20
                    s_d.st  = ST_RUNNING;
                    s_d.cnt = '0;
                end
            end
            ST_RUNNING: begin
                // trigger level only picks the state left to on an opening; it never stops the timer
                if (opened) begin                                 // RULE_07 RULE_10
                    s_d.st = trig ? ST_REJECTED : ST_STANDBY;     // RULE_11
                end else if (s_q.cnt + 24'h000001 >= tim_act) begin
                    s_d.st   = ST_FAILED;
                    s_d.trip = 1'b1;                              // RULE_08
                    s_d.lock = 1'b1;                              // RULE_13
                end else begin
                    s_d.cnt = s_q.cnt + 24'h000001;
                end
            end
            ST_REJECTED: begin
                if (!trig) begin
                    s_d.st = ST_STANDBY;                          // RULE_12
                end
            end
            ST_FAILED: begin
                if (!trig) begin
                    s_d.st = ST_STANDBY;
                end
            end
            default: s_d.st = ST_STANDBY;
        endcase
        // register writes
        if (wr) begin
            case (wb_adr_i)
                REG_CTRL: s_d.ctrl = merge(s_q.ctrl, wb_dat_i, wb_sel_i);
                REG_ACK: begin
                    // a new trip in the same cycle keeps the lockout
                    if (wb_sel_i[0] && wb_dat_i[0] && !s_d.trip) begin
                        s_d.lock = 1'b0;                          // RULE_13
                    end
                end
                default: begin
                    for (int i = 0; i < NUM_SETS; i++) begin
                        if (wb_adr_i == REG_THR0 + 8'(i) * REG_STRIDE) begin
                            s_d.thr[i] = 16'(merge({16'h0000, s_q.thr[i]},
                                                   wb_dat_i, wb_sel_i));
                        end
                        if (wb_adr_i == REG_TIME0 + 8'(i) * REG_STRIDE) begin
                            s_d.tim[i] = 24'(merge({8'h00, s_q.tim[i]},
                                                   wb_dat_i, wb_sel_i));
                        end
                    end
                end
            endcase
        end
        // read data, unmapped reads return zero
        s_d.rdat = 32'h0000_0000;
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                REG_CTRL:   s_d.rdat = s_q.ctrl;
                REG_STATUS: s_d.rdat = {26'h0, off_nom, trig, s_q.lock,
                                        s_q.trip, 2'(s_q.st)};
                default: begin
                    for (int i = 0; i < NUM_SETS; i++) begin
                        if (wb_adr_i == REG_THR0 + 8'(i) * REG_STRIDE) begin
                            s_d.rdat = {16'h0000, s_q.thr[i]};
                        end
                        if (wb_adr_i == REG_TIME0 + 8'(i) * REG_STRIDE) begin
                            s_d.rdat = {8'h00, s_q.tim[i]};
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.ctrl <= CTRL_RST;
            s_q.thr  <= {NUM_SETS{THR_RST}};
            s_q.tim  <= {NUM_SETS{TIME_RST}};
            s_q.st   <= ST_STANDBY;
            s_q.cnt  <= '0;
            s_q.trip <= 1'b0;
            s_q.lock <= 1'b0;
            s_q.ack  <= 1'b0;
            s_q.rdat <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o      = s_q.ack;
    assign wb_dat_o      = s_q.rdat;
    assign backup_trip_o = s_q.trip;
    assign lockout_o     = s_q.lock;  // RULE_14

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_trip_with_lock: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
        backup_trip_o |-> lockout_o)
        else $error("trip without lockout");

    // the clearing write is the one taken at this edge, ack still low
    a_lock_holds: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
        lockout_o && !(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                       && wb_adr_i == REG_ACK) |=> lockout_o)
        else $error("lockout dropped without acknowledge");

    a_trip_cause: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        $rose(backup_trip_o) |-> $past(s_q.st) == ST_RUNNING
                                 && s_q.st == ST_FAILED)
        else $error("trip not from expiry");

    a_trip_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        backup_trip_o |=> !backup_trip_o)
        else $error("backup trip longer than one cycle");

    a_stop_on_open: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        s_q.st == ST_RUNNING && opened |=> s_q.st != ST_FAILED
                                        && !backup_trip_o)
        else $error("trip despite opening");

    a_reject_entry: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
        s_q.st == ST_RUNNING && opened && trig |=> s_q.st == ST_REJECTED)
        else $error("rejected state not entered");

    a_reject_exit: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
        s_q.st == ST_REJECTED && !trig |=> s_q.st == ST_STANDBY)
        else $error("rejected state not left");

    a_run_persists: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        s_q.st == ST_RUNNING && !trig && !opened
            && s_q.cnt + 24'h000001 < tim_act |=> s_q.st == ST_RUNNING)
        else $error("timer stopped by trigger drop");

    a_start_edge: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_20
        s_q.st == ST_STANDBY && trig_rise |=> s_q.st == ST_RUNNING
                                           && s_q.cnt == '0)
        else $error("trigger edge did not start timer");

    a_freq_block: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
        off_nom && s_q.ctrl[1:0] == 2'h0 |-> !opened)
        else $error("current scheme not blocked");
endmodule // bfm_monitor

//--- rtl/bfm_pkg.sv
// shared constants and types for the breaker failure monitor
package bfm_pkg;
    // ------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00; // scheme, trigger mode, transformer select, set
    localparam logic [7:0] REG_THR0   = 8'h04; // current-drop threshold, set 0
    localparam logic [7:0] REG_TIME0  = 8'h14; // supervision time in cycles, set 0
    localparam logic [7:0] REG_STATUS = 8'h24; // state, trip, lockout
    localparam logic [7:0] REG_ACK    = 8'h28; // write bit 0 clears lockout
    localparam logic [7:0] REG_STRIDE = 8'h04; // spacing of per-set registers

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CTRL_SCHEME_LSB = 0;  // 2 bits
    localparam int CTRL_TRIG_LSB   = 2;  // 2 bits
    localparam int CTRL_XSEL_BIT   = 4;  // transformer select
    localparam int CTRL_SET_LSB    = 5;  // 2 bits

    // ------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------
    localparam int          CUR_W       = 16;          // current magnitude width
    localparam int          TIME_W      = 24;          // supervision count width
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [15:0] THR_RST     = 16'h0100;
    localparam logic [23:0] TIME_RST    = 24'h0004e2;  // 1250 cycles = 50 us at 25 MHz
    localparam int          NUM_SETS    = 4;
    localparam int          NUM_EXTRA   = 3;
    localparam int          FREQ_PCT    = 5;           // frequency margin in percent

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCH_CURRENT,
        SCH_POSITION,
        SCH_COMBINED
    } bfm_scheme_t;

    typedef enum logic [1:0] {
        TRG_ALL,
        TRG_EXTERNAL,
        TRG_NONE
    } bfm_trig_t;

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_RUNNING,
        ST_REJECTED,
        ST_FAILED
    } bfm_state_t;
endpackage

//--- rtl/bfm_trigger.sv
// trigger source selection and start edge
`timescale 1ns/100ps
module bfm_trigger #(
    parameter int NT = 8
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [1:0]    mode_i,        // trigger mode
    input  wire logic [NT-1:0] trip_all_i,    // trips assigned to breaker
    input  wire logic [NT-1:0] trip_ext_i,    // marks which are external
    input  wire logic [2:0]    extra_trig_i,  // three extra trigger inputs
    output logic               trig_o,        // effective trigger level
    output logic               trig_rise_o    // one-cycle rising edge
);
    import bfm_pkg::*;

    typedef struct packed {
        logic last;
    } bfm_tr_state_t;

    bfm_tr_state_t s_q;
    bfm_tr_state_t s_d;
    logic          mode_src;  // trip group picked by the mode

    // ------------------------------------------------------------
    // source select
    // ------------------------------------------------------------
    always_comb begin
        case (bfm_trig_t'(mode_i))
            TRG_ALL:      mode_src = |trip_all_i;                 // RULE_15
            TRG_EXTERNAL: mode_src = |(trip_all_i & trip_ext_i);  // RULE_16
            default:      mode_src = 1'b0;                        // RULE_18
        endcase
        trig_o  = mode_src | (|extra_trig_i);  // RULE_17 RULE_20
        s_d.last = trig_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign trig_rise_o = trig_o & ~s_q.last;  // RULE_20
endmodule // bfm_trigger
